//--- rtl/bbh_pkg.sv
/*
 * bbh_pkg: constants, encodings and carrier types for the buck/boost
 * hibernate configuration block.
 * Assumes a 16-bit register view placed on a 32-bit APB word bus.
 */
package bbh_pkg;

	// ****************************************************************
	// register map (indices; byte address is index times four)
	// ****************************************************************
	localparam int         ADDR_W          = 12;
	localparam logic [9:0] IDX_BUCK1_CTRL  = 10'h0B4;
	localparam logic [9:0] IDX_BUCK1_LP    = 10'h0B6;
	localparam logic [9:0] IDX_CONV2_CTRL  = 10'h0B7;
	localparam logic [9:0] IDX_SLEEP_CTRL  = 10'h0C0;
	localparam logic [9:0] IDX_STATUS      = 10'h0C1;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int B1_VCODE_LSB   = 0;
	localparam int B1_MODE_LSB    = 12;
	localparam int B1_SRC_LSB     = 8;
	localparam int B1_ALT_LSB     = 0;
	localparam int C2_TOPO_BIT    = 14;
	localparam int C2_SLEEP_BIT   = 12;
	localparam int C2_SRC_LSB     = 8;
	localparam int C2_LIM_BIT     = 6;
	localparam int C2_RHI_BIT     = 4;
	localparam int C2_RLO_BIT     = 3;
	localparam int C2_FB_LSB      = 0;
	localparam int SLP_REG_BIT    = 0;

	// ****************************************************************
	// reset values and writable masks
	// ****************************************************************
	localparam logic [15:0] BUCK1_CTRL_RST = 16'h000E;
	localparam logic [15:0] BUCK1_LP_RST   = 16'h1006;
	localparam logic [15:0] CONV2_CTRL_RST = 16'h0018;
	localparam logic [15:0] SLEEP_CTRL_RST = 16'h0000;
	localparam logic [15:0] BUCK1_CTRL_MSK = 16'h007F;
	localparam logic [15:0] BUCK1_LP_MSK   = 16'h737F;
	localparam logic [15:0] CONV2_CTRL_MSK = 16'h535B;
	localparam logic [15:0] SLEEP_CTRL_MSK = 16'h0001;

	// ****************************************************************
	// voltage code scale
	// ****************************************************************
	localparam logic [11:0] BUCK_BASE_MV  = 12'h352;
	localparam logic [11:0] BUCK_STEP_MV  = 12'h019;
	localparam logic [6:0]  BUCK_MAX_CODE = 7'h66;
	localparam logic [1:0]  RAMP_USB      = 2'h3;

	// ****************************************************************
	// encodings
	// ****************************************************************
	typedef enum logic [2:0] {
		B1_KEEP     = 3'b000,
		B1_ALT      = 3'b001,
		B1_STBY     = 3'b010,
		B1_STBY_ALT = 3'b011,
		B1_LDO      = 3'b100,
		B1_LDO_ALT  = 3'b101,
		B1_RSVD     = 3'b110,
		B1_OFF      = 3'b111
	} bbh_b1_sleep_t;

	typedef enum logic [1:0] {
		SRC_REG  = 2'b00,
		SRC_LP_A = 2'b01,
		SRC_LP_B = 2'b10,
		SRC_LP_C = 2'b11
	} bbh_src_t;

	typedef enum logic [1:0] {
		FB_PIN    = 2'b00,
		FB_SINK_A = 2'b01,
		FB_SINK_B = 2'b10,
		FB_USB    = 2'b11
	} bbh_fb_t;

	// ****************************************************************
	// carriers toward the power stages
	// ****************************************************************
	typedef struct packed {
		logic        en;
		logic        standby;
		logic        ldo;
		logic [6:0]  vcode;
		logic [11:0] mv;
	} bbh_buck1_t;

	typedef struct packed {
		logic       en;
		logic       switch_mode;
		logic       low_limit;
		logic [1:0] ramp;
		bbh_fb_t    fb_src;
		logic       usb_div;
	} bbh_conv2_t;

endpackage : bbh_pkg

//--- rtl/bbh_pin_sync.sv
/*
 * bbh_pin_sync: three-stage synchroniser for one asynchronous pin.
 * Assumes the pin may change at any time relative to clk.
 */
`timescale 1ns/1ps
module bbh_pin_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// pin and result
	input  wire logic pin,
	output logic      level
);
	import bbh_pkg::*;

	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// stage one feeds only stage two
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// accept a change only once two stages agree, filters one-cycle glitches
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			level <= 1'b0;
		end else if (s2_reg == s3_reg) begin
			level <= s3_reg;
		end
	end

endmodule : bbh_pin_sync

//--- rtl/bbh_sleep_sel.sv
/*
 * bbh_sleep_sel: picks one converter's hibernate source.
 * Assumes all inputs are already in the clk domain.
 */
`timescale 1ns/1ps
module bbh_sleep_sel (
	// selection
	input  bbh_pkg::bbh_src_t source,
	// candidate sources
	input  wire logic         reg_bit,
	input  wire logic [2:0]   lp_in,
	input  wire logic         gpio_hib,
	// result
	output logic              active
);
	import bbh_pkg::*;

	logic picked;

	// trigger field chooses one source; gpio input always adds in
	always_comb begin
		case (source)
			SRC_REG:  picked = reg_bit;
			SRC_LP_A: picked = lp_in[0];
			SRC_LP_B: picked = lp_in[1];
			default:  picked = lp_in[2];
		endcase
		active = picked | gpio_hib;
	end

endmodule : bbh_sleep_sel

//--- rtl/bbh_top.sv
/*
 * bbh_top: register file and hibernate selection for a buck converter
 * and a boost/switch converter, reached over APB.
 * Assumes a 10 MHz clk, pin inputs asynchronous to it, and a one-cycle
 * field_reset pulse from the power state machine on the same clock.
 * Reserved buck code 110 acts as 000; ramp forcing shows on outputs only.
 */
// Added by the designer: register access over APB.
`timescale 1ns/1ps
module bbh_top (
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    arst_n,
	input  wire logic                    field_reset,
	// apb slave
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [bbh_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// hibernate sources (asynchronous pins)
	input  wire logic                    low_power_input_a,
	input  wire logic                    low_power_input_b,
	input  wire logic                    low_power_input_c,
	input  wire logic                    gpio_hib,
	// enables from start-up sequencing
	input  wire logic                    buck1_on_req,
	input  wire logic                    conv2_on_req,
	// converter controls
	output bbh_pkg::bbh_buck1_t          buck1_out,
	output bbh_pkg::bbh_conv2_t          conv2_out,
	output logic                         buck1_sleeping,
	output logic                         conv2_sleeping
);
	import bbh_pkg::*;

	// ****************************************************************
	// declarations
	// ****************************************************************
	logic [15:0]   buck1_ctrl_reg;
	logic [15:0]   buck1_lp_reg;
	logic [15:0]   conv2_ctrl_reg;
	logic [15:0]   sleep_ctrl_reg;
	logic [31:0]   rdata_next;
	logic          hit;
	logic [9:0]    idx;
	logic          wr_en;
	logic [3:0]    pins_raw;
	logic [3:0]    pins_sync;
	logic          b1_hib;
	logic          c2_hib;
	bbh_buck1_t    buck1_next;
	bbh_conv2_t    conv2_next;
	bbh_b1_sleep_t b1_mode;
	logic [6:0]    b1_code;
	logic          b1_use_alt;
	logic [1:0]    c2_ramp_field;
	logic [5:0]    status_vec;
	logic          c2_sleep_off;

	// ****************************************************************
	// pin synchronisers
	// ****************************************************************
	assign pins_raw = {gpio_hib, low_power_input_c, low_power_input_b, low_power_input_a};

	// one synchroniser per asynchronous hibernate source
	for (genvar i = 0; i < 4; i++) begin : g_sync
		bbh_pin_sync u_sync (
			.clk    (clk),
			.arst_n (arst_n),
			.pin    (pins_raw[i]),
			.level  (pins_sync[i])
		);
	end

	// ****************************************************************
	// apb decode
	// ****************************************************************
	assign idx    = paddr[ADDR_W-1:2];
	assign pready = 1'b1; // zero wait states
	assign wr_en  = psel && penable && pwrite && hit;

	// status word: synced pins above the two hibernate flags
	assign status_vec = {pins_sync, c2_hib, b1_hib};

	// map check on word index; low two address bits ignored
	always_comb begin
		hit        = 1'b1;
		rdata_next = 32'h0000_0000;
		if (idx == IDX_BUCK1_CTRL) begin
			rdata_next[15:0] = buck1_ctrl_reg;
		end else if (idx == IDX_BUCK1_LP) begin
			rdata_next[15:0] = buck1_lp_reg;
		end else if (idx == IDX_CONV2_CTRL) begin
			rdata_next[15:0] = conv2_ctrl_reg;
		end else if (idx == IDX_SLEEP_CTRL) begin
			rdata_next[15:0] = sleep_ctrl_reg;
		end else if (idx == IDX_STATUS) begin
			rdata_next[5:0] = status_vec;
		end else begin
			hit = 1'b0;
		end
	end

	// error only in the access phase of an unmapped transfer
	assign pslverr = psel && penable && !hit;

	// read data captured in setup so it is a flop in the access phase
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= rdata_next;
		end
	end

	// ****************************************************************
	// configuration registers
	// ****************************************************************
	// buck normal voltage code; state machine reset wins over a write
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			buck1_ctrl_reg <= BUCK1_CTRL_RST;
		end else if (field_reset) begin
			buck1_ctrl_reg <= BUCK1_CTRL_RST;
		end else if (wr_en && idx == IDX_BUCK1_CTRL) begin
			buck1_ctrl_reg <= pwdata[15:0] & BUCK1_CTRL_MSK;
		end
	end

	// buck hibernate mode, trigger and image code
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			buck1_lp_reg <= BUCK1_LP_RST;
		end else if (field_reset) begin
			buck1_lp_reg <= BUCK1_LP_RST;
		end else if (wr_en && idx == IDX_BUCK1_LP) begin
			buck1_lp_reg <= pwdata[15:0] & BUCK1_LP_MSK;
		end
	end

	// converter two fields; written ramp bits kept even when forced
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			conv2_ctrl_reg <= CONV2_CTRL_RST;
		end else if (field_reset) begin
			conv2_ctrl_reg <= CONV2_CTRL_RST;
		end else if (wr_en && idx == IDX_CONV2_CTRL) begin
			conv2_ctrl_reg <= pwdata[15:0] & CONV2_CTRL_MSK;
		end
	end

	// hibernate register bit; mask keeps unused bits reading zero
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sleep_ctrl_reg <= SLEEP_CTRL_RST;
		end else if (field_reset) begin
			sleep_ctrl_reg <= SLEEP_CTRL_RST;
		end else if (wr_en && idx == IDX_SLEEP_CTRL) begin
			sleep_ctrl_reg <= pwdata[15:0] & SLEEP_CTRL_MSK;
		end
	end

	// ****************************************************************
	// hibernate source selection
	// ****************************************************************
	// buck source from its trigger field
	bbh_sleep_sel u_b1_sel (
		.source   (bbh_src_t'(buck1_lp_reg[B1_SRC_LSB +: 2])),
		.reg_bit  (sleep_ctrl_reg[SLP_REG_BIT]),
		.lp_in    (pins_sync[2:0]),
		.gpio_hib (pins_sync[3]),
		.active   (b1_hib)
	);

	// converter two source, same encoding
	bbh_sleep_sel u_c2_sel (
		.source   (bbh_src_t'(conv2_ctrl_reg[C2_SRC_LSB +: 2])),
		.reg_bit  (sleep_ctrl_reg[SLP_REG_BIT]),
		.lp_in    (pins_sync[2:0]),
		.gpio_hib (pins_sync[3]),
		.active   (c2_hib)
	);

	// ****************************************************************
	// buck converter behaviour
	// ****************************************************************
	assign b1_mode = bbh_b1_sleep_t'(buck1_lp_reg[B1_MODE_LSB +: 3]);

	// hibernate overrides are derived, fields untouched, so exit is automatic
	always_comb begin
		buck1_next.en      = buck1_on_req;
		buck1_next.standby = 1'b0;
		buck1_next.ldo     = 1'b0;
		b1_use_alt         = 1'b0;
		if (b1_hib) begin
			case (b1_mode)
				B1_KEEP: begin
					b1_use_alt = 1'b0;
				end
				B1_ALT: begin
					b1_use_alt = 1'b1;
				end
				B1_STBY: begin
					buck1_next.standby = 1'b1;
				end
				B1_STBY_ALT: begin
					buck1_next.standby = 1'b1;
					b1_use_alt         = 1'b1;
				end
				B1_LDO: begin
					buck1_next.ldo = 1'b1;
				end
				B1_LDO_ALT: begin
					buck1_next.ldo = 1'b1;
					b1_use_alt     = 1'b1;
				end
				B1_OFF: begin
					buck1_next.en = 1'b0;
				end
				// reserved code acts as no change, like code 000
				default: begin
					b1_use_alt = 1'b0;
				end
			endcase
		end
		// normal code outside hibernate, image code when asked for
		b1_code = b1_use_alt ? buck1_lp_reg[B1_ALT_LSB +: 7]
		                     : buck1_ctrl_reg[B1_VCODE_LSB +: 7];
		// codes past the top step are held at the maximum voltage
		if (b1_code > BUCK_MAX_CODE) begin
			b1_code = BUCK_MAX_CODE;
		end
		buck1_next.vcode = b1_code;
		buck1_next.mv    = BUCK_BASE_MV + BUCK_STEP_MV * {5'h00, b1_code};
	end

	// ****************************************************************
	// converter two behaviour
	// ****************************************************************
	assign c2_ramp_field = {conv2_ctrl_reg[C2_RHI_BIT], conv2_ctrl_reg[C2_RLO_BIT]};

	// output off only while hibernate lasts and the disable bit is set
	assign c2_sleep_off = c2_hib && conv2_ctrl_reg[C2_SLEEP_BIT];

	always_comb begin
		conv2_next.switch_mode = conv2_ctrl_reg[C2_TOPO_BIT];
		conv2_next.low_limit   = conv2_ctrl_reg[C2_LIM_BIT];
		conv2_next.fb_src      = bbh_fb_t'(conv2_ctrl_reg[C2_FB_LSB +: 2]);
		conv2_next.usb_div     = (conv2_next.fb_src == FB_USB);
		// usb feedback implies the lowest output range
		conv2_next.ramp = conv2_next.usb_div ? RAMP_USB : c2_ramp_field;
		// sleep disable gates the enable only while hibernate lasts
		conv2_next.en = conv2_on_req && !c2_sleep_off;
	end

	// ****************************************************************
	// registered outputs
	// ****************************************************************
	// one flop stage keeps buck control lines glitch free toward the stage
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			buck1_out      <= '0;
			buck1_sleeping <= 1'b0;
		end else begin
			buck1_out      <= buck1_next;
			buck1_sleeping <= b1_hib;
		end
	end

	// converter two controls, same single flop stage
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			conv2_out      <= '0;
			conv2_sleeping <= 1'b0;
		end else begin
			conv2_out      <= conv2_next;
			conv2_sleeping <= c2_hib;
		end
	end

endmodule : bbh_top

//--- verif/bbh_top_chk.sv
/*
 * bbh_top_chk: port-level assertions for bbh_top.
 * Assumes a bind to bbh_top and a single clock domain.
 */
`timescale 1ns/1ps
module bbh_top_chk (
	// clock and reset
	input wire logic                       clk,
	input wire logic                       arst_n,
	input wire logic                       field_reset,
	// apb
	input wire logic                       psel,
	input wire logic                       penable,
	input wire logic                       pwrite,
	input wire logic [bbh_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0]                pwdata,
	input wire logic [31:0]                prdata,
	input wire logic                       pslverr,
	// converter side
	input wire logic                       buck1_on_req,
	input wire logic                       conv2_on_req,
	input bbh_pkg::bbh_buck1_t             buck1_out,
	input bbh_pkg::bbh_conv2_t             conv2_out,
	input wire logic                       buck1_sleeping
);
	import bbh_pkg::*;
	// ****************************************************************
	// properties
	// ****************************************************************
	logic mapped;
	// decode kept apart from the design so a bad index shows up
	assign mapped = paddr[11:2] inside {IDX_BUCK1_CTRL, IDX_BUCK1_LP, IDX_CONV2_CTRL,
		IDX_SLEEP_CTRL, IDX_STATUS};
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	// a converter-two write that field_reset does not cancel
	sequence s_c2_wr;
		psel && penable && pwrite && paddr[11:2] == IDX_CONV2_CTRL && !field_reset;
	endsequence
	chk_mv_scale: assert property (
		$past(arst_n) |-> buck1_out.mv == 12'h352 + 12'h019 * {5'h00, buck1_out.vcode})
		else $error("mv off scale");
	chk_code_max: assert property (buck1_out.vcode <= 7'h66) else $error("code above max");
	chk_ramp_usb: assert property (
		conv2_out.fb_src == FB_USB |-> conv2_out.ramp == 2'h3) else $error("ramp not forced");
	chk_usb_div: assert property (
		conv2_out.usb_div == (conv2_out.fb_src == FB_USB)) else $error("usb divider wrong");
	chk_buck_en: assert property (
		buck1_out.en |-> $past(buck1_on_req)) else $error("buck on unrequested");
	chk_conv2_en: assert property (
		conv2_out.en |-> $past(conv2_on_req)) else $error("conv2 on unrequested");
	chk_mode_sleep: assert property (
		buck1_out.standby || buck1_out.ldo |-> buck1_sleeping || $past(buck1_sleeping))
		else $error("forced mode outside sleep");
	chk_stby_ldo: assert property (
		!(buck1_out.standby && buck1_out.ldo)) else $error("standby and ldo together");
	chk_err_map: assert property ( // refused index flags error
		psel && penable |-> pslverr == !mapped) else $error("pslverr wrong");
	chk_upper_zero: assert property (prdata[31:16] == 16'h0000) else $error("upper read bits set");
	chk_c2_fields: assert property (s_c2_wr |-> ##2 (
		conv2_out.switch_mode == $past(pwdata[14], 2) && conv2_out.low_limit == $past(pwdata[6], 2)
		&& conv2_out.fb_src == $past(pwdata[1:0], 2))) else $error("conv2 fields wrong");
	chk_c2_ramp: assert property (s_c2_wr |-> ##2 conv2_out.ramp ==
		($past(pwdata[1:0], 2) == 2'h3 ? 2'h3 : $past(pwdata[4:3], 2))) else $error("ramp wrong");
endmodule : bbh_top_chk

//--- verif/bbh_stage_model.sv
/*
 * bbh_stage_model: power state machine stand-in giving enables and field reset.
 * Assumes the bench raises power_up and clear_req on rising edges.
 */
`timescale 1ns/1ps
module bbh_stage_model #(
	parameter int LAG = 3
) (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// bench requests
	input wire logic power_up,
	input wire logic clear_req,
	// toward the block
	output logic     buck1_on_req,
	output logic     conv2_on_req,
	output logic     field_reset
);
	// ****************************************************************
	// sequencing
	// ****************************************************************
	logic [3:0] cnt_reg;
	logic       clr_reg;
	// enables come LAG+1 cycles after power_up rises, like a slow start-up slot
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg      <= 4'h0;
			buck1_on_req <= 1'b0;
			conv2_on_req <= 1'b0;
		end else begin
			cnt_reg      <= !power_up ? 4'h0 : (cnt_reg == LAG) ? cnt_reg : cnt_reg + 4'h1;
			buck1_on_req <= power_up && cnt_reg == LAG;
			conv2_on_req <= power_up && cnt_reg == LAG;
		end
	end
	// one-cycle pulse only, however long the request stays up
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			clr_reg     <= 1'b0;
			field_reset <= 1'b0;
		end else begin
			clr_reg     <= clear_req;
			field_reset <= clear_req && !clr_reg;
		end
	end
endmodule : bbh_stage_model

//--- verif/bbh_top_bench.sv
/*
 * bbh_top_bench: self-checking bench for bbh_top over APB.
 * Assumes bbh_stage_model supplies enables and field reset.
 */
`timescale 1ns/1ps
bind bbh_top bbh_top_chk chk_i (.clk, .arst_n, .field_reset, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pslverr, .buck1_on_req, .conv2_on_req, .buck1_out, .conv2_out,
	.buck1_sleeping);
module bbh_top_bench;
	import bbh_pkg::*;
	// ****************************************************************
	// signals and tables
	// ****************************************************************
	logic        clk, arst_n, field_reset, psel, penable, pwrite, pready, pslverr, e;
	logic        gpio_hib, b1_on, c2_on, power_up, clear_req, b1_slp, c2_slp;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] d;
	logic [6:0]  r;
	logic [2:0]  lp;
	logic [1:0]  f;
	bbh_buck1_t  b1;
	bbh_conv2_t  c2;
	int          err_count, n_tests, i, p;
	// rows: mode, then expected en, standby, ldo, image code in use
	localparam logic [6:0]  ROWS [8] = '{7'h08, 7'h19, 7'h2C, 7'h3D, 7'h4A, 7'h5B, 7'h68, 7'h70};
	localparam logic [9:0]  DIDX [4] = '{IDX_BUCK1_CTRL, IDX_BUCK1_LP, IDX_CONV2_CTRL, IDX_SLEEP_CTRL};
	localparam logic [15:0] DVAL [4] = '{16'h000E, 16'h1006, 16'h0018, 16'h0000};
	always #50 clk = ~clk;
	bbh_top uut (.clk, .arst_n, .field_reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .low_power_input_a(lp[0]), .low_power_input_b(lp[1]),
		.low_power_input_c(lp[2]), .gpio_hib, .buck1_on_req(b1_on), .conv2_on_req(c2_on),
		.buck1_out(b1), .conv2_out(c2), .buck1_sleeping(b1_slp), .conv2_sleeping(c2_slp));
	bbh_stage_model #(.LAG(3)) model (.clk, .arst_n, .power_up, .clear_req,
		.buck1_on_req(b1_on), .conv2_on_req(c2_on), .field_reset);
	// ****************************************************************
	// tasks
	// ****************************************************************
	task give_verdict;
		$display("errors %0d, checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict
	task cmp_out(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			err_count++;
			$display("Error at %0t: output %h, expected %h", $time, g, x);
		end
	endtask : cmp_out
	task cmp_word(input logic [31:0] g, input logic [31:0] x);
		n_tests++;
		if (g !== x) begin
			err_count++;
			$display("Error at %0t: read %h, expected %h", $time, g, x);
		end
	endtask : cmp_word
	// one apb transfer; holds everything until pready is seen high
	task apb(input logic w, input logic [9:0] idx, input logic [15:0] wd);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= {16'h0000, wd};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			err_count++;
			give_verdict;
		end
		q = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// sample on the falling edge so registered outputs have settled
	task look(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask : look
	task drive(input logic [2:0] l, input logic g);
		@(posedge clk);
		lp       <= l;
		gpio_hib <= g;
	endtask : drive
	task chk_defaults;
		for (int k = 0; k < 4; k++) begin
			apb(1'b0, DIDX[k], 16'h0000);
			cmp_word(q, {16'h0000, DVAL[k]});
		end
	endtask : chk_defaults
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{clk, arst_n, psel, penable, pwrite, gpio_hib, power_up, clear_req} = 8'h00;
		{paddr, pwdata, lp, err_count, n_tests} = '0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		chk_defaults;
		apb(1'b0, 10'h0B5, 16'h0000);
		cmp_word(q, 32'h0000_0000);
		cmp_out(e, 1'b1);
		@(posedge clk);
		power_up <= 1'b1;
		for (i = 0; i < 20 && !(b1_on === 1'b1 && c2_on === 1'b1); i++) @(posedge clk);
		if (i == 20) begin
			err_count++;
			give_verdict;
		end
		apb(1'b1, IDX_BUCK1_CTRL, 16'h0000);
		for (i = 0; i < 8; i++) begin
			r = ROWS[i];
			apb(1'b1, IDX_BUCK1_LP, {1'b0, r[6:4], 12'h066});
			apb(1'b1, IDX_SLEEP_CTRL, 16'h0001);
			look(3);
			cmp_out({b1.en, b1.standby, b1.ldo}, r[3:1]);
			if (r[3]) cmp_out({b1.vcode, b1.mv}, r[0] ? {7'h66, 12'hD48} : {7'h00, 12'h352});
			apb(1'b1, IDX_SLEEP_CTRL, 16'h0000);
			look(3);
			cmp_out({b1.en, b1.standby, b1.ldo, b1.vcode}, {3'b100, 7'h00});
		end
		apb(1'b1, IDX_BUCK1_CTRL, 16'h007F);
		look(3);
		cmp_out({b1.vcode, b1.mv}, {7'h66, 12'hD48});
		for (i = 1; i < 4; i++) begin
			apb(1'b1, IDX_BUCK1_LP, {4'h1, 2'b00, i[1:0], 8'h06});
			apb(1'b1, IDX_CONV2_CTRL, {6'h00, i[1:0], 8'h18});
			for (p = 0; p < 3; p++) begin
				drive(3'b001 << p, 1'b0);
				look(8);
				cmp_out({c2_slp, b1_slp}, (p == i - 1) ? 2'b11 : 2'b00);
			end
		end
		drive(3'b000, 1'b1);
		look(8);
		cmp_out({c2_slp, b1_slp}, 2'b11);
		apb(1'b0, IDX_STATUS, 16'h0000);
		cmp_word(q, 32'h0000_0023);
		apb(1'b1, IDX_CONV2_CTRL, 16'h1018);
		look(3);
		cmp_out(c2.en, 1'b0);
		apb(1'b1, IDX_CONV2_CTRL, 16'h0018);
		look(3);
		cmp_out(c2.en, 1'b1);
		drive(3'b000, 1'b0);
		for (i = 0; i < 4; i++) begin
			f = i[1:0];
			d = {1'b0, f[0], 7'h00, f[1], 1'b0, f[1], ~f[0], 1'b0, f};
			apb(1'b1, IDX_CONV2_CTRL, d);
			look(3);
			cmp_out({c2.switch_mode, c2.low_limit, c2.ramp, c2.fb_src, c2.usb_div},
				{f[0], f[1], (f == 2'h3) ? 2'h3 : {f[1], ~f[0]}, f, f == 2'h3});
			apb(1'b0, IDX_CONV2_CTRL, 16'h0000);
			cmp_word(q, {16'h0000, d});
		end
		@(posedge clk);
		clear_req <= 1'b1;
		repeat (3) @(posedge clk);
		clear_req <= 1'b0;
		chk_defaults;
		@(posedge clk);
		arst_n <= 1'b0;
		look(1);
		cmp_out({b1, c2}, 32'h0000_0000);
		@(posedge clk);
		arst_n <= 1'b1;
		chk_defaults;
		give_verdict;
	end
endmodule : bbh_top_bench
